// ### rtl/acc_top.sv
// Analog comparator control: sensing, pin output, reference and status
module acc_top
  import acc_pkg::*;
#(
  parameter int unsigned NUM_COMP = ACC_NUM_COMP,
  parameter int unsigned REF_W    = ACC_REF_CODE_W
)
(
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  wire logic [NUM_COMP-1:0]           comp_raw,
  input  wire logic [NUM_COMP*ACC_SEL_W-1:0] adc_trigger_select,
  input  wire logic [NUM_COMP*ACC_SEL_W-1:0] int_sense_select,
  input  wire logic [NUM_COMP*ACC_SRC_W-1:0] reference_source_select,
  input  wire logic [NUM_COMP-1:0]           out_invert,
  input  wire logic [NUM_COMP-1:0]           int_enable,
  input  wire logic [NUM_COMP-1:0]           int_clear,
  input  wire logic                          masked_status_select,
  input  wire logic [REF_W-1:0]              ref_level_code,
  input  wire logic                          ref_on,
  output logic [NUM_COMP-1:0]                comp_pin_out,
  output logic [NUM_COMP-1:0]                adc_trigger,
  output logic                               cpu_irq,
  output logic [NUM_COMP-1:0]                int_status,
  output logic [NUM_COMP-1:0]                comp_value,
  output logic [NUM_COMP*ACC_SRC_W-1:0]      analog_source_route,
  output logic [NUM_COMP-1:0]                shared_positive_input,
  output logic [REF_W-1:0]                   ref_level_out,
  output logic                               ref_enable_out
);

  // Elaboration-time refusal of widths the logic cannot serve
  if (NUM_COMP < 1 || NUM_COMP > 8) begin : g_bad_num_comp
    $error("acc_top: NUM_COMP must be 1 to 8");
  end
  if (REF_W < 1 || REF_W > 8) begin : g_bad_ref_w
    $error("acc_top: REF_W must be 1 to 8");
  end

  logic [NUM_COMP-1:0] sync_val;
  logic [NUM_COMP-1:0] trig_val;
  logic [NUM_COMP-1:0] pend;
  logic [NUM_COMP-1:0] masked;
  logic [NUM_COMP-1:0] pin_next;
  logic [NUM_COMP*ACC_SRC_W-1:0] src_next;

  genvar g;
  generate
    for (g = 0; g < NUM_COMP; g++) begin : g_chan
      logic [1:0] src_sel;

      acc_sense u_sense (
        .clk       (clk),
        .rst_b     (rst_b),
        .comp_raw  (comp_raw[g]),
        .trig_sel  (adc_trigger_select[g*ACC_SEL_W +: ACC_SEL_W]),
        .int_sel   (int_sense_select[g*ACC_SEL_W +: ACC_SEL_W]),
        .int_clear (int_clear[g]),
        .comp_sync (sync_val[g]),
        .adc_trig  (trig_val[g]),
        .int_pend  (pend[g])
      );

      assign pin_next[g] = sync_val[g] ^ out_invert[g];

      // Reference source routing; unused code falls back to own pin
      assign src_sel = reference_source_select[g*ACC_SRC_W +: ACC_SRC_W];
      always_comb begin
        src_next[g*ACC_SRC_W +: ACC_SRC_W] = ACC_SRC_OWN_PIN;
        if (src_sel == ACC_SRC_SHARED_PIN && g != 0) begin
          src_next[g*ACC_SRC_W +: ACC_SRC_W] = ACC_SRC_SHARED_PIN;
        end else if (src_sel == ACC_SRC_INTERNAL) begin
          src_next[g*ACC_SRC_W +: ACC_SRC_W] = ACC_SRC_INTERNAL;
        end
      end
    end
  endgenerate

  assign masked = pend & int_enable;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cpu_irq <= ACC_PEND_RST;
    end else begin
      cpu_irq <= |masked;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      int_status <= '0;
    end else begin
      int_status <= masked_status_select ? masked : pend;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      comp_value <= '0;
    end else begin
      comp_value <= sync_val;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      comp_pin_out <= '0;
    end else begin
      comp_pin_out <= pin_next;
    end
  end

  assign adc_trigger = trig_val;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      analog_source_route   <= {NUM_COMP{ACC_SRC_SEL_RST}};
      shared_positive_input <= '0;
    end else begin
      analog_source_route <= src_next;
      for (int i = 0; i < NUM_COMP; i++) begin
        shared_positive_input[i] <=
          (src_next[i*ACC_SRC_W +: ACC_SRC_W] == ACC_SRC_SHARED_PIN) || (i == 0 &&
          reference_source_select[ACC_SRC_W-1:0] == ACC_SRC_SHARED_PIN);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ref_level_out  <= '0;
      ref_enable_out <= ACC_REF_ON_RST;
    end else begin
      ref_level_out  <= ref_on ? ref_level_code : '0;
      ref_enable_out <= ref_on;
    end
  end

endmodule

// ### common/acc_pkg.sv
// Shared constants and encodings for the analog comparator control block
package acc_pkg;

  // Comparator count and internal reference code width
  localparam int unsigned ACC_NUM_COMP      = 3;
  localparam int unsigned ACC_REF_CODE_W    = 5;

  // Sense selection encodings (shared by ADC trigger and interrupt sense)
  typedef enum logic [2:0] {
    ACC_SENSE_NONE = 3'h0,
    ACC_SENSE_HIGH = 3'h1,
    ACC_SENSE_LOW  = 3'h2,
    ACC_SENSE_FALL = 3'h3,
    ACC_SENSE_RISE = 3'h4,
    ACC_SENSE_BOTH = 3'h5
  } acc_sense_t;

  // Reference source selection encodings
  typedef enum logic [1:0] {
    ACC_SRC_OWN_PIN    = 2'h0,
    ACC_SRC_SHARED_PIN = 2'h1,
    ACC_SRC_INTERNAL   = 2'h2
  } acc_src_t;

  // Values after reset
  localparam logic [2:0] ACC_TRIG_SEL_RST   = 3'h0;
  localparam logic [2:0] ACC_INT_SEL_RST    = 3'h0;
  localparam logic [1:0] ACC_SRC_SEL_RST    = 2'h0;
  localparam logic       ACC_INT_EN_RST     = 1'h0;
  localparam logic       ACC_PEND_RST       = 1'h0;
  localparam logic       ACC_SYNC_RST       = 1'h0;
  localparam logic [4:0] ACC_REF_CODE_RST   = 5'h00;
  localparam logic       ACC_REF_ON_RST     = 1'h0;

  // Field widths in the packed per-comparator select buses
  localparam int unsigned ACC_SEL_W         = 3;
  localparam int unsigned ACC_SRC_W         = 2;

endpackage

// ### rtl/acc_sense.sv
// One comparator channel: synchroniser, level/edge sense, pending flag
module acc_sense
  import acc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       comp_raw,
  input  wire logic [2:0] trig_sel,
  input  wire logic [2:0] int_sel,
  input  wire logic       int_clear,
  output logic            comp_sync,
  output logic            adc_trig,
  output logic            int_pend
);

  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic rise;
  logic fall;
  logic trig_next;
  logic int_cond;
  logic int_level;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync1_reg <= ACC_SYNC_RST;
      sync2_reg <= ACC_SYNC_RST;
    end else begin
      sync1_reg <= comp_raw;
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prev_reg <= ACC_SYNC_RST;
    end else begin
      prev_reg <= sync2_reg;
    end
  end

  assign comp_sync = sync2_reg;
  assign rise      = sync2_reg & ~prev_reg;
  assign fall      = ~sync2_reg & prev_reg;

  // Shared sense decoder for trigger and interrupt
  function automatic logic sense(input logic [2:0] sel, input logic lvl,
                                 input logic r, input logic f);
    logic res;
    res = 1'b0;
    case (sel)
      ACC_SENSE_HIGH: res = lvl;
      ACC_SENSE_LOW:  res = ~lvl;
      ACC_SENSE_FALL: res = f;
      ACC_SENSE_RISE: res = r;
      ACC_SENSE_BOTH: res = r | f;
      default:        res = 1'b0;
    endcase
    return res;
  endfunction

  // Level trigger modes, edge trigger modes
  assign trig_next = sense(trig_sel, sync2_reg, rise, fall);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      adc_trig <= ACC_PEND_RST;
    end else begin
      adc_trig <= trig_next;
    end
  end

  // Level interrupt modes, edge interrupt modes
  assign int_cond  = sense(int_sel, sync2_reg, rise, fall);
  assign int_level = (int_sel == ACC_SENSE_HIGH) || (int_sel == ACC_SENSE_LOW);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      int_pend <= ACC_PEND_RST;
    end else if (int_cond) begin
      int_pend <= 1'b1;
    end else if (int_clear || int_level) begin
      int_pend <= 1'b0;
    end
  end

endmodule

// ### verif/acc_chk.sv
// Port checker for the comparator control block
module acc_chk
  import acc_pkg::*;
#(
  parameter int unsigned NUM_COMP = 3,
  parameter int unsigned REF_W    = 5
)
(
  input wire logic                 clk,
  input wire logic                 rst_b,
  input wire logic [NUM_COMP-1:0]  comp_raw,
  input wire logic [NUM_COMP*3-1:0] adc_trigger_select,
  input wire logic [NUM_COMP*3-1:0] int_sense_select,
  input wire logic [NUM_COMP-1:0]  out_invert,
  input wire logic [NUM_COMP-1:0]  int_enable,
  input wire logic [NUM_COMP-1:0]  int_clear,
  input wire logic                 masked_status_select,
  input wire logic [REF_W-1:0]     ref_level_code,
  input wire logic                 ref_on,
  input wire logic [NUM_COMP-1:0]  comp_pin_out,
  input wire logic [NUM_COMP-1:0]  adc_trigger,
  input wire logic                 cpu_irq,
  input wire logic [NUM_COMP-1:0]  int_status,
  input wire logic [NUM_COMP-1:0]  comp_value,
  input wire logic [REF_W-1:0]     ref_level_out,
  input wire logic                 ref_enable_out
);
  logic [2:0] up_reg;
  // Cycles since reset release, so history is valid
  always_ff @(posedge clk) begin
    if (!rst_b) up_reg <= 3'h0;
    else if (up_reg != 3'h7) up_reg <= up_reg + 3'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b || up_reg != 3'h7);
  sequence clr_s;
    int_clear[0] && int_sense_select[2:0] == ACC_SENSE_RISE
    ##1 !(comp_value[0] && !$past(comp_value[0])) && !masked_status_select;
  endsequence
  value_sync_a: assert property (comp_value == $past(comp_raw, 3))
    else $error("comparator value not three cycles behind");
  pin_pol_a: assert property (comp_pin_out == (comp_value ^ $past(out_invert)))
    else $error("pin polarity wrong");
  irq_gate_a: assert property (!$past(masked_status_select) |->
    cpu_irq == |(int_status & $past(int_enable))) else $error("irq not gated");
  masked_stat_a: assert property ($past(masked_status_select) |->
    (int_status & ~$past(int_enable)) == '0) else $error("masked status wrong");
  trig_high_a: assert property ($past(adc_trigger_select[2:0]) == ACC_SENSE_HIGH |->
    adc_trigger[0] == comp_value[0]) else $error("high trigger wrong");
  trig_low_a: assert property ($past(adc_trigger_select[2:0]) == ACC_SENSE_LOW |->
    adc_trigger[0] == !comp_value[0]) else $error("low trigger wrong");
  trig_rise_a: assert property ($past(adc_trigger_select[2:0]) == ACC_SENSE_RISE |->
    adc_trigger[0] == (comp_value[0] && !$past(comp_value[0])))
    else $error("rise trigger wrong");
  int_level_a: assert property ($past(int_sense_select[2:0]) == ACC_SENSE_HIGH
    && comp_value[0] && !masked_status_select |=> int_status[0])
    else $error("level interrupt lost");
  int_clear_a: assert property (clr_s |=> !int_status[0])
    else $error("clear ignored");
  ref_out_a: assert property (ref_enable_out == $past(ref_on) &&
    ref_level_out == ($past(ref_on) ? $past(ref_level_code) : '0))
    else $error("reference output wrong");
endmodule
bind acc_top acc_chk #(.NUM_COMP(NUM_COMP), .REF_W(REF_W)) chk_i (
  .clk(clk), .rst_b(rst_b), .comp_raw(comp_raw),
  .adc_trigger_select(adc_trigger_select), .int_sense_select(int_sense_select),
  .out_invert(out_invert), .int_enable(int_enable), .int_clear(int_clear),
  .masked_status_select(masked_status_select), .ref_level_code(ref_level_code),
  .ref_on(ref_on), .comp_pin_out(comp_pin_out), .adc_trigger(adc_trigger),
  .cpu_irq(cpu_irq), .int_status(int_status), .comp_value(comp_value),
  .ref_level_out(ref_level_out), .ref_enable_out(ref_enable_out));

// ### verif/acc_far_model.sv
// ADC trigger input and interrupt controller: counts asserted cycles
module acc_far_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       trig_in,
  input  wire logic       irq_in,
  input  wire logic       zero,
  output logic [7:0]      trig_cnt,
  output logic [7:0]      irq_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge clk) begin
    if (!rst_b || zero) begin
      trig_cnt <= 8'h00;
      irq_cnt <= 8'h00;
    end else begin
      trig_cnt <= trig_cnt + {7'h00, trig_in};
      irq_cnt <= irq_cnt + {7'h00, irq_in};
    end
  end
endmodule

// ### verif/acc_top_bench.sv
// Self-checking bench for the comparator control block
module acc_top_bench import acc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0, rst_b = 1'b0, msel = 1'b0, ref_on = 1'b0, zero = 1'b0;
  logic [2:0] raw = 3'h0, inv = 3'h0, ien = 3'h0, iclr = 3'h0;
  logic [8:0] tsel = 9'h000, isel = 9'h000;
  logic [5:0] ssel = 6'h00;
  logic [4:0] rcode = 5'h00;
  logic [2:0] pin, trg, stat, val, shp;
  logic [5:0] route;
  logic [4:0] rlv;
  logic       irq, ren;
  logic [7:0] tcnt, icnt;
  int         fail_count = 0, num_checks = 0, cyc = 0;
  int         exp_t [6] = '{0, 6, 18, 1, 1, 2};
  always #50 clk = ~clk;
  acc_top dut (.clk(clk), .rst_b(rst_b), .comp_raw(raw), .adc_trigger_select(tsel),
    .int_sense_select(isel), .reference_source_select(ssel), .out_invert(inv),
    .int_enable(ien), .int_clear(iclr), .masked_status_select(msel),
    .ref_level_code(rcode), .ref_on(ref_on), .comp_pin_out(pin), .adc_trigger(trg),
    .cpu_irq(irq), .int_status(stat), .comp_value(val), .analog_source_route(route),
    .shared_positive_input(shp), .ref_level_out(rlv), .ref_enable_out(ren));
  acc_far_model far (.clk(clk), .rst_b(rst_b), .trig_in(trg[0]), .irq_in(irq),
    .zero(zero), .trig_cnt(tcnt), .irq_cnt(icnt));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    #1;
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 2000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    tick(2);
    rst_b <= 1'b1;
    ien <= 3'h1;
    iclr <= 3'h1;
    // Each trigger mode against a different interrupt mode, clear held
    for (int m = 0; m < 6; m++) begin
      tick(1);
      tsel[2:0] <= 3'(m);
      isel[2:0] <= 3'(5 - m);
      zero <= 1'b1;
      tick(1);
      zero <= 1'b0;
      tick(5);
      raw <= 3'h7;
      tick(6);
      raw <= 3'h0;
      tick(12);
      tsel[2:0] <= 3'h0;
      isel[2:0] <= 3'h0;
      tick(6);
      chk(tcnt, 8'(exp_t[m]));
      chk(icnt, 8'(exp_t[5 - m]));
    end
    tick(1);
    inv <= 3'h5;
    raw <= 3'h7;
    ssel <= 6'h24;
    isel[2:0] <= 3'h1;
    tsel[5:3] <= 3'h1;
    ien <= 3'h0;
    iclr <= 3'h0;
    tick(6);
    chk({5'h00, val}, 8'h07);
    chk({5'h00, pin}, 8'h02);
    chk({2'h0, route}, 8'h24);
    chk({5'h00, shp}, 8'h02);
    chk({5'h00, trg}, 8'h02);
    chk({5'h00, stat}, 8'h01);
    chk({7'h00, irq}, 8'h00);
    tick(1);
    msel <= 1'b1;
    ref_on <= 1'b1;
    rcode <= 5'h13;
    tick(3);
    chk({5'h00, stat}, 8'h00);
    chk({3'h0, rlv}, 8'h13);
    chk({7'h00, ren}, 8'h01);
    tick(1);
    ien <= 3'h1;
    ref_on <= 1'b0;
    tick(3);
    chk({5'h00, stat}, 8'h01);
    chk({7'h00, irq}, 8'h01);
    chk({3'h0, rlv}, 8'h00);
    end_of_test();
  end
endmodule
